//--- verilog/bcc_consts.vh
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH
// register offsets (8-bit address space)
`define BCC_OFS_CH3_ACT 8'h30
`define BCC_OFS_CH3_LPM 8'h31
`define BCC_OFS_CH3_HIB 8'h32
`define BCC_OFS_CH3_HPM 8'h33
`define BCC_OFS_CH3_SEQ 8'h34
`define BCC_OFS_CH3_CFG 8'h35
`define BCC_OFS_CH4_ACT 8'h40
`define BCC_OFS_CH4_LPM 8'h41
`define BCC_OFS_CH4_HIB 8'h42
`define BCC_OFS_CH4_HPM 8'h43
`define BCC_OFS_CH4_SEQ 8'h44
`define BCC_OFS_CH4_CFG 8'h45
// per-state register fields
`define BCC_EN_BIT 7
`define BCC_MODE_BIT 6
`define BCC_VOLTAGE_CODE_MSB 5
`define BCC_VOLTAGE_CODE_LSB 0
// sequencing register fields
`define BCC_SSR_MSB 7
`define BCC_SSR_LSB 6
`define BCC_STEP_MSB 5
`define BCC_STEP_LSB 4
`define BCC_SEQUENCE_ENABLE_BIT 3
`define BCC_DLY_MSB 2
`define BCC_DLY_LSB 0
// configuration register fields
`define BCC_FMASK_BIT 7
`define BCC_HICCUP_BIT 6
`define BCC_OUTPUT_DISCHARGE_BIT 5
`define BCC_PHASE_BIT 4
`define BCC_VOLTAGE_SCALING_RATE_MSB 3
`define BCC_VOLTAGE_SCALING_RATE_LSB 2
`define BCC_REN_BIT 1
`define BCC_OVR_BIT 0
// reset values
`define BCC_RST_CH3_ACT 8'hE7
`define BCC_RST_CH3_LPM 8'hA7
`define BCC_RST_CH3_HIB 8'h27
`define BCC_RST_CH3_HPM 8'hE7
`define BCC_RST_CH3_SEQ 8'h2C
`define BCC_RST_CH3_CFG 8'hB0
`define BCC_RST_CH4_ACT 8'hFD
`define BCC_RST_CH4_LPM 8'hBD
`define BCC_RST_CH4_HIB 8'hBD
`define BCC_RST_CH4_HPM 8'hFD
`define BCC_RST_CH4_SEQ 8'h1C
`define BCC_RST_CH4_CFG 8'hA0
// power states
`define BCC_PS_ACT 2'h0
`define BCC_PS_LPM 2'h1
`define BCC_PS_HIB 2'h2
`define BCC_PS_HPM 2'h3
// timing
`define BCC_CLK_MHZ 250
`define BCC_RESTART_MS 100
`define BCC_TICK_US 1
`endif

//--- verilog/bcc_delay_timer.v
`timescale 1ns/1ps
// counts down a load value in units of the tick pulse; done pulses once at zero
module bcc_delay_timer #(
  parameter WIDTH = 17
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // control
  input wire tick,
  input wire load,
  input wire [WIDTH-1:0] loadValue,
  input wire abort,
  // status
  output reg busy_reg,
  output reg done_reg
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_reg <= {WIDTH{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (abort) begin
        busy_reg <= 1'b0;
      end else if (load) begin
        count_reg <= loadValue;
        busy_reg <= 1'b1;
      end else if (busy_reg && tick) begin
        if (count_reg == {WIDTH{1'b0}}) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // bcc_delay_timer

//--- verilog/bcc_buck_regs.v
`timescale 1ns/1ps
`include "bcc_consts.vh"

module bcc_buck_regs #(
  parameter DELAY_UNIT_US = 1000,
  parameter RESTART_MS = `BCC_RESTART_MS
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // register port from the serial bus engine
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata_reg,
  output reg regHit_reg,
  // system state
  input wire [1:0] powerState,
  input wire startupEvent,
  // analog status pins, per channel (bit 0 third, bit 1 fourth)
  input wire [1:0] softStartDonePin,
  input wire [1:0] powerGoodPin,
  input wire [1:0] shortCircuitPin,
  input wire [1:0] channelFaultPin,
  // analog controls, per channel
  output reg [1:0] channelOn_reg,
  output reg [1:0] forcedFixedFreqMode_reg,
  output reg [11:0] voltageCode_reg,
  output reg [3:0] softStartRate_reg,
  output reg [3:0] voltageScalingRate_reg,
  output reg [1:0] outputDischarge_reg,
  output reg [1:0] phaseInvert_reg,
  output reg [1:0] softStartRestart_reg,
  // interrupt pin, active low
  output reg interruptOut_n_reg
);
  localparam [31:0] CYC_PER_US = `BCC_CLK_MHZ * `BCC_TICK_US;
  localparam [31:0] RESTART_US = RESTART_MS * 1000;
  localparam [31:0] DELAY_TICKS = DELAY_UNIT_US;
  localparam SEQ_IDLE = 2'h0;
  localparam SEQ_WAIT = 2'h1;
  localparam SEQ_STEP = 2'h2;
  localparam SEQ_RUN = 2'h3;

  reg [7:0] stateReg_reg [0:1][0:3];
  reg [7:0] seqReg_reg [0:1];
  reg [7:0] cfgReg_reg [0:1];

  // pin synchronisers
  reg [7:0] pinMeta_reg;
  reg [7:0] pinSync_reg;
  wire [1:0] ssDone = pinSync_reg[1:0];
  wire [1:0] pGood = pinSync_reg[3:2];
  wire [1:0] shorted = pinSync_reg[5:4];
  wire [1:0] faulted = pinSync_reg[7:6];

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinMeta_reg <= 8'h00;
      pinSync_reg <= 8'h00;
    end else begin
      pinMeta_reg <= {channelFaultPin, shortCircuitPin, powerGoodPin, softStartDonePin};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // start-up request comes from outside the clock domain too
  reg startMeta_reg;
  reg startSync_reg;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      startMeta_reg <= 1'b0;
      startSync_reg <= 1'b0;
    end else begin
      startMeta_reg <= startupEvent;
      startSync_reg <= startMeta_reg;
    end
  end

  // 1 us tick enable
  reg [7:0] usCnt_reg;
  reg usTick_reg;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      usCnt_reg <= 8'h00;
      usTick_reg <= 1'b0;
    end else begin
      usTick_reg <= (usCnt_reg == CYC_PER_US[7:0] - 8'h01);
      if (usCnt_reg == CYC_PER_US[7:0] - 8'h01) begin
        usCnt_reg <= 8'h00;
      end else begin
        usCnt_reg <= usCnt_reg + 8'h01;
      end
    end
  end

  // register map decode
  reg hit;
  reg [2:0] sel;
  reg chSel;
  always @* begin
    hit = 1'b1;
    // 0x3x is the third channel, 0x4x the fourth
    chSel = regAddr[6];
    sel = regAddr[2:0];
    if (regAddr[7:4] != 4'h3 && regAddr[7:4] != 4'h4) begin
      hit = 1'b0;
    end
    if (regAddr[3:0] > 4'h5) begin
      hit = 1'b0;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stateReg_reg[0][0] <= `BCC_RST_CH3_ACT;
      stateReg_reg[0][1] <= `BCC_RST_CH3_LPM;
      stateReg_reg[0][2] <= `BCC_RST_CH3_HIB;
      stateReg_reg[0][3] <= `BCC_RST_CH3_HPM;
      stateReg_reg[1][0] <= `BCC_RST_CH4_ACT;
      stateReg_reg[1][1] <= `BCC_RST_CH4_LPM;
      stateReg_reg[1][2] <= `BCC_RST_CH4_HIB;
      stateReg_reg[1][3] <= `BCC_RST_CH4_HPM;
      seqReg_reg[0] <= `BCC_RST_CH3_SEQ;
      seqReg_reg[1] <= `BCC_RST_CH4_SEQ;
      cfgReg_reg[0] <= `BCC_RST_CH3_CFG;
      cfgReg_reg[1] <= `BCC_RST_CH4_CFG;
      regRdata_reg <= 8'h00;
      regHit_reg <= 1'b0;
    end else begin
      regHit_reg <= (regRead | regWrite) & hit;
      if (regWrite && hit) begin
        case (sel)
          3'h4: seqReg_reg[chSel] <= regWdata;
          3'h5: cfgReg_reg[chSel] <= regWdata;
          default: stateReg_reg[chSel][sel[1:0]] <= regWdata;
        endcase
      end
      if (regRead) begin
        if (!hit) begin
          regRdata_reg <= 8'h00;
        end else begin
          case (sel)
            3'h4: regRdata_reg <= seqReg_reg[chSel];
            3'h5: regRdata_reg <= cfgReg_reg[chSel];
            default: regRdata_reg <= stateReg_reg[chSel][sel[1:0]];
          endcase
        end
      end
    end
  end

  // power-up sequencer shared by both channels
  reg [1:0] seqState_reg;
  reg [1:0] stepNow_reg;
  reg [1:0] seqStarted_reg;
  reg restartPending_reg;
  reg autoKick_reg;
  reg tmrLoad;
  reg [16:0] tmrValue;
  wire tmrDone;
  reg [1:0] stepMatch;
  reg [1:0] stepReady;
  reg [1:0] delayStep;
  reg [1:0] delayMatch;
  reg [2:0] stepDelay;
  reg anyHardShort;
  integer c;

  always @* begin
    stepDelay = 3'h0;
    anyHardShort = 1'b0;
    // a delay loaded while in a step belongs to the step that follows
    delayStep = (seqState_reg == SEQ_STEP) ? stepNow_reg + 2'h1 : 2'h0;
    for (c = 0; c < 2; c = c + 1) begin
      stepMatch[c] = seqReg_reg[c][`BCC_SEQUENCE_ENABLE_BIT] &&
        (seqReg_reg[c][`BCC_STEP_MSB:`BCC_STEP_LSB] == stepNow_reg);
      delayMatch[c] = seqReg_reg[c][`BCC_SEQUENCE_ENABLE_BIT] &&
        (seqReg_reg[c][`BCC_STEP_MSB:`BCC_STEP_LSB] == delayStep);
      // flags of skipped channels do not hold the sequence back
      stepReady[c] = !stepMatch[c] || (ssDone[c] && pGood[c]);
      if (delayMatch[c] && seqReg_reg[c][`BCC_DLY_MSB:`BCC_DLY_LSB] > stepDelay) begin
        stepDelay = seqReg_reg[c][`BCC_DLY_MSB:`BCC_DLY_LSB];
      end
      if (shorted[c] && !cfgReg_reg[c][`BCC_HICCUP_BIT] && channelOn_reg[c]) begin
        anyHardShort = 1'b1;
      end
    end
  end

  always @* begin
    tmrLoad = 1'b0;
    tmrValue = 17'h0_0000;
    if (anyHardShort) begin
      tmrLoad = 1'b1;
      tmrValue = RESTART_US[16:0];
    end else if ((seqState_reg == SEQ_IDLE && (startSync_reg || autoKick_reg)) ||
        (seqState_reg == SEQ_STEP && stepReady == 2'b11 && stepNow_reg != 2'h3)) begin
      tmrLoad = 1'b1;
      tmrValue = DELAY_TICKS[16:0] * {14'h0000, stepDelay};
    end
  end

  // one timer serves both the step delays and the restart wait
  bcc_delay_timer #(
    .WIDTH(17)
  ) delayTimer (
    .core_clk(core_clk),
    .reset(reset),
    .tick(usTick_reg),
    .load(tmrLoad),
    .loadValue(tmrValue),
    .abort(1'b0),
    .busy_reg(),
    .done_reg(tmrDone)
  );

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      seqState_reg <= SEQ_IDLE;
      stepNow_reg <= 2'h0;
      seqStarted_reg <= 2'b00;
      restartPending_reg <= 1'b0;
    end else begin
      case (seqState_reg)
        SEQ_IDLE: begin
          if (tmrLoad && !anyHardShort) begin
            stepNow_reg <= 2'h0;
            seqState_reg <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (tmrDone) begin
            restartPending_reg <= 1'b0;
            if (restartPending_reg) begin
              stepNow_reg <= 2'h0;
              seqState_reg <= SEQ_IDLE;
            end else begin
              seqStarted_reg <= seqStarted_reg | stepMatch;
              seqState_reg <= SEQ_STEP;
            end
          end
        end
        SEQ_STEP: begin
          if (stepReady == 2'b11) begin
            if (stepNow_reg == 2'h3) begin
              seqState_reg <= SEQ_RUN;
            end else begin
              stepNow_reg <= stepNow_reg + 2'h1;
              seqState_reg <= SEQ_WAIT;
            end
          end
        end
        SEQ_RUN: begin
          seqState_reg <= SEQ_RUN;
        end
        default: seqState_reg <= SEQ_IDLE;
      endcase
      // hard short overrides everything, all channels off, restart later
      if (anyHardShort) begin
        seqStarted_reg <= 2'b00;
        restartPending_reg <= 1'b1;
        seqState_reg <= SEQ_WAIT;
      end
    end
  end

  // a restart after the wait re-enters idle; auto-kick the new sequence
  // so no fresh start-up request is needed after a hard short
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      autoKick_reg <= 1'b0;
    end else begin
      autoKick_reg <= tmrDone && restartPending_reg;
    end
  end

  // per-channel outputs
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire [7:0] cur = stateReg_reg[g][powerState];
      wire [7:0] cfg = cfgReg_reg[g];
      wire wantOn = cfg[`BCC_OVR_BIT] ? cfg[`BCC_REN_BIT] : cur[`BCC_EN_BIT];
      wire seqOk = seqStarted_reg[g] || (seqState_reg == SEQ_RUN);
      always @(posedge core_clk or posedge reset) begin
        if (reset) begin
          channelOn_reg[g] <= 1'b0;
          forcedFixedFreqMode_reg[g] <= 1'b0;
          voltageCode_reg[g*6 +: 6] <= 6'h00;
          softStartRate_reg[g*2 +: 2] <= 2'h0;
          voltageScalingRate_reg[g*2 +: 2] <= 2'h0;
          outputDischarge_reg[g] <= 1'b0;
          phaseInvert_reg[g] <= 1'b0;
          softStartRestart_reg[g] <= 1'b0;
        end else begin
          // sequencer gates turn-on; override bypasses it, but a hard short or pending restart still forces off
          channelOn_reg[g] <= (cfg[`BCC_OVR_BIT] || seqOk) && wantOn && !anyHardShort &&
            !restartPending_reg;
          forcedFixedFreqMode_reg[g] <= cur[`BCC_MODE_BIT];
          voltageCode_reg[g*6 +: 6] <= cur[`BCC_VOLTAGE_CODE_MSB:`BCC_VOLTAGE_CODE_LSB];
          softStartRate_reg[g*2 +: 2] <= seqReg_reg[g][`BCC_SSR_MSB:`BCC_SSR_LSB];
          voltageScalingRate_reg[g*2 +: 2] <= cfg[`BCC_VOLTAGE_SCALING_RATE_MSB:`BCC_VOLTAGE_SCALING_RATE_LSB];
          outputDischarge_reg[g] <= cfg[`BCC_OUTPUT_DISCHARGE_BIT] && !channelOn_reg[g];
          phaseInvert_reg[g] <= cfg[`BCC_PHASE_BIT];
          // hiccup: hold retry on this channel only while its short stands, others keep running
          softStartRestart_reg[g] <= shorted[g] && cfg[`BCC_HICCUP_BIT] &&
            channelOn_reg[g];
        end
      end
    end
  endgenerate

  // interrupt: low while any unmasked channel fault stands
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      interruptOut_n_reg <= 1'b1;
    end else begin
      interruptOut_n_reg <= !((faulted[0] && !cfgReg_reg[0][`BCC_FMASK_BIT]) ||
        (faulted[1] && !cfgReg_reg[1][`BCC_FMASK_BIT]));
    end
  end

endmodule // bcc_buck_regs

//--- bench/bcc_buck_regs_sva.sv
`timescale 1ns/1ps
module bcc_buck_regs_sva (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // register port
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdata_reg,
  input wire regHit_reg,
  // state and pins
  input wire [1:0] powerState,
  input wire [1:0] channelFaultPin,
  // controls
  input wire [1:0] channelOn_reg,
  input wire [11:0] voltageCode_reg,
  input wire [1:0] outputDischarge_reg,
  input wire interruptOut_n_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire mapped = (regAddr[7:4] == 4'h3 || regAddr[7:4] == 4'h4) && regAddr[3:0] <= 4'h5;

  AST_HIT: assert property ((regRead || regWrite) && mapped |=> regHit_reg)
    else $error("mapped access gave no hit");
  AST_MISS_RD: assert property (regRead && !mapped |=> regRdata_reg == 8'h00 && !regHit_reg)
    else $error("unmapped read not refused");
  AST_MISS_WR: assert property (regWrite && !mapped |=> !regHit_reg)
    else $error("unmapped write gave a hit");
  AST_HIT_CAUSE: assert property (regHit_reg |-> $past(regRead || regWrite))
    else $error("hit without an access");
  AST_RD_HOLD: assert property (!$past(regRead) |-> $stable(regRdata_reg))
    else $error("read data moved without a read");
  // fault pin passes a two-flop sync first, so allow a small window
  AST_INT_CAUSE: assert property ($fell(interruptOut_n_reg) |->
    ($past(channelFaultPin, 2) | $past(channelFaultPin, 3) | $past(channelFaultPin, 4)) != 2'b00)
    else $error("interrupt fell with no fault");
  AST_OUTPUT_DISCHARGE_OFF: assert property (outputDischarge_reg[0] |->
    !channelOn_reg[0] || !$past(channelOn_reg[0]))
    else $error("discharge while channel on");
  AST_VCODE: assert property (!$past(regWrite, 2) && !$past(regWrite, 3) && !$past(reset)
    && !$past(reset, 2) && $past(powerState) == $past(powerState, 2) |-> $stable(voltageCode_reg))
    else $error("voltage code moved with no cause");

  COV_READ: cover property (regRead && mapped);
  COV_INT: cover property ($fell(interruptOut_n_reg));
  COV_ON: cover property ($rose(channelOn_reg[1]));
endmodule // bcc_buck_regs_sva

bind bcc_buck_regs bcc_buck_regs_sva bcc_buck_regs_sva_i (.*);

//--- bench/bcc_host_model.sv
`timescale 1ns/1ps
module bcc_host_model (
  // clock
  input wire core_clk,
  // register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWdata,
  input wire [7:0] regRdata_reg,
  input wire regHit_reg
);
  initial {regAddr, regWrite, regRead, regWdata} = '0;
  // released lines show the inverse so stale values never pass
  task wr(input logic [7:0] a, input logic [7:0] v);
    regAddr = a;
    regWdata = v;
    regWrite = 1;
    @(posedge core_clk);
    #1 regWrite = 0;
    regAddr = ~a;
    regWdata = ~v;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v, output logic h);
    regAddr = a;
    regRead = 1;
    @(posedge core_clk);
    #1 regRead = 0;
    regAddr = ~a;
    v = regRdata_reg;
    h = regHit_reg;
    // idle edge so back-to-back calls never retoggle in one step
    @(posedge core_clk);
    #1;
  endtask
endmodule // bcc_host_model

//--- bench/bcc_buck_regs_tb_top.sv
`timescale 1ns/1ps
module bcc_buck_regs_tb_top;
  logic core_clk = 0, reset = 1, startupEvent = 0;
  logic [1:0] powerState = 0, shortCircuitPin = 0, channelFaultPin = 0;
  wire [7:0] regAddr, regWdata, regRdata_reg;
  wire regWrite, regRead, regHit_reg, interruptOut_n_reg;
  wire [1:0] channelOn_reg, forcedFixedFreqMode_reg, outputDischarge_reg, phaseInvert_reg;
  wire [1:0] softStartDonePin, powerGoodPin, softStartRestart_reg;
  wire [11:0] voltageCode_reg;
  wire [3:0] softStartRate_reg, voltageScalingRate_reg;
  int failures = 0, n_tests = 0, cyc = 0, n;
  logic [7:0] d;
  logic h;
  // {hit, address, reset value}
  logic [16:0] rows [13] = '{{1'b1, 8'h30, 8'hE7}, {1'b1, 8'h31, 8'hA7}, {1'b1, 8'h32, 8'h27},
    {1'b1, 8'h33, 8'hE7}, {1'b1, 8'h34, 8'h2C}, {1'b1, 8'h35, 8'hB0}, {1'b1, 8'h40, 8'hFD},
    {1'b1, 8'h41, 8'hBD}, {1'b1, 8'h42, 8'hBD}, {1'b1, 8'h43, 8'hFD}, {1'b1, 8'h44, 8'h1C},
    {1'b1, 8'h45, 8'hA0}, {1'b0, 8'h36, 8'h00}};
  // ideal plant: done and good as soon as a channel is on
  assign softStartDonePin = channelOn_reg;
  assign powerGoodPin = channelOn_reg;
  // restart wait cut to one tick so the auto restart fits the run
  bcc_buck_regs #(.DELAY_UNIT_US(1), .RESTART_MS(0)) bcc_buck_regs_i (.*);
  bcc_host_model bcc_host_model_i (.*);

  initial forever #2 core_clk = ~core_clk;
  task tick(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task check(string nm, logic [11:0] e, logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task wreg(logic [7:0] a, logic [7:0] v);
    bcc_host_model_i.wr(a, v);
    tick(3);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict;
    end
  end

  initial begin
    tick(2);
    reset = 0;
    for (int i = 0; i < 13; i++) begin
      bcc_host_model_i.rd(rows[i][15:8], d, h);
      check("rdata", rows[i][7:0], d);
      check("hit", rows[i][16], h);
    end
    check("vcode", {6'h3D, 6'h27}, voltageCode_reg);
    check("phase", 2'b01, phaseInvert_reg);
    check("output_discharge", 2'b11, outputDischarge_reg);
    for (int s = 0; s < 4; s++) begin
      wreg(8'h40 + s, {1'b1, s[0], 6'h10 + s[5:0]});
      powerState = s;
      tick(3);
      check("vcode4", 6'h10 + s, voltageCode_reg[11:6]);
      check("vcode3", 6'h27, voltageCode_reg[5:0]);
      check("mode", {s[0], s == 0 || s == 3}, forcedFixedFreqMode_reg);
    end
    wreg(8'h45, 8'hA3);
    check("on", 1, channelOn_reg[1]);
    check("output_discharge", 2'b01, outputDischarge_reg);
    check("mode", 2'b11, forcedFixedFreqMode_reg);
    powerState = 2;
    tick(3);
    check("mode", 2'b00, forcedFixedFreqMode_reg);
    wreg(8'h45, 8'hA1);
    check("on", 0, channelOn_reg[1]);
    wreg(8'h45, 8'hA2);
    check("on", 0, channelOn_reg[1]);
    // fault first masked by the reset value, then unmasked
    channelFaultPin = 2'b01;
    tick(8);
    check("int", 1, interruptOut_n_reg);
    wreg(8'h35, 8'h38);
    tick(3);
    check("int", 0, interruptOut_n_reg);
    channelFaultPin = 0;
    check("voltage_scaling_rate", 2, voltageScalingRate_reg[1:0]);
    wreg(8'h34, 8'hEC);
    check("ssr", 3, softStartRate_reg[1:0]);
    // fourth channel on step 1, third on step 2, delay 4 us each
    powerState = 0;
    wreg(8'h45, 8'hA0);
    startupEvent = 1;
    for (n = 0; n < 5000 && channelOn_reg[1] !== 1'b1; n++) tick(1);
    check("on", 2'b10, channelOn_reg);
    for (n = 0; n < 5000 && channelOn_reg[0] !== 1'b1; n++) tick(1);
    check("late", 1, n >= 1000 && n < 1300);
    // hard short with hiccup clear takes every channel down, then restarts alone
    startupEvent = 0;
    shortCircuitPin = 2'b01;
    tick(5);
    check("on", 0, channelOn_reg);
    shortCircuitPin = 0;
    for (n = 0; n < 8000 && channelOn_reg !== 2'b11; n++) tick(1);
    check("on", 2'b11, channelOn_reg);
    // hiccup on the fourth channel retries it alone, third keeps running
    wreg(8'h45, 8'hE0);
    shortCircuitPin = 2'b10;
    tick(4);
    check("retry", 2'b10, softStartRestart_reg);
    check("on", 2'b11, channelOn_reg);
    shortCircuitPin = 0;
    tick(4);
    check("retry", 2'b00, softStartRestart_reg);
    reset = 1;
    tick(2);
    reset = 0;
    bcc_host_model_i.rd(8'h35, d, h);
    check("rdata", 8'hB0, d);
    check("int", 1, interruptOut_n_reg);
    // fourth channel left out of the sequence: third still starts, fourth still off at that moment
    wreg(8'h44, 8'h14);
    startupEvent = 1;
    for (n = 0; n < 5000 && channelOn_reg[0] !== 1'b1; n++) tick(1);
    check("on", 2'b01, channelOn_reg);
    give_verdict;
  end
endmodule // bcc_buck_regs_tb_top
